// ===== core/pwm_timer_consts.svh
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH
// register addresses
`define ADR_CTRL0      8'h00
`define ADR_CTRL1      8'h04
`define ADR_EDGE       8'h08
`define ADR_CYCLE      8'h0c
`define ADR_SECOND     8'h10
`define ADR_COUNT      8'h14
`define ADR_OPTION     8'h18
`define ADR_CAPCTL     8'h1c
// field positions
`define CE_BIT         0
`define MODE_MSB       2
`define MODE_LSB       0
`define SWTRIG_BIT     3
`define TRIG_SEL_MSB   1
`define TRIG_SEL_LSB   0
`define EVT_SEL_MSB    3
`define EVT_SEL_LSB    2
`define CAP_MSB        3
`define CAP_LSB        0
`define OPT_MSB        7
`define OPT_LSB        4
`define MODE_RESET     3'b000
`define FIELD_RESET    4'h0
`define WRAP_BIT       0
`define EDGE_W_MASK    16'h000f
`define CTRL1_W_MASK   16'h0007
`define CAPCTL_W_MASK  16'h000f
`define OPTION_W_MASK  16'h00f0
// modes and counter values
`define MODE_EVENT     3'b001
`define MODE_TRIGGER   3'b010
`define CNT_ALL_ONES   16'hffff
`define CNT_ZERO       16'h0000
`define CNT_ONE        16'h0001
`define DATA_ZERO      16'h0000
`define CMP_RESET      16'hffff
`define DIV_ONE        8'h01
`define DIV_ZERO       8'h00
`endif

// ===== core/pwm_timer_pkg.sv
package pwm_timer_pkg;
	typedef enum logic [1:0] {
		EDGE_NONE    = 2'b00,
		EDGE_RISING  = 2'b01,
		EDGE_FALLING = 2'b10,
		EDGE_BOTH    = 2'b11
	} edge_sel_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN  = 3'b100
	} timer_state_t;
	typedef logic [15:0] word_t;
	typedef logic [7:0]  addr_t;
endpackage : pwm_timer_pkg

// ===== core/event_trigger_timer.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"
// Notes on behaviour
// - event mode counts one step per detected valid edge of the event input.
// - cycle value all ones: counter reaches FFFFH, wraps to 0000H, then cycle match.
// - that all-ones wrap leaves the wrap flag untouched.
// - event mode copies a cycle compare write into its buffer at once.
// - counter past a smaller new cycle value runs to FFFFH, wraps, then matches.
// - event mode second match fires once per cycle when within the cycle value.
// - second value above the cycle value never matches, no second match.
// - mode field 010 selects trigger pulse output mode.
// - trigger mode waits after enable; first trigger clears FFFFH to 0000H, runs.
// - retrigger while running clears to 0000H, restarts, toggles timer output a.
// - every trigger drives the pwm output high.
// - active width is second value counts, cycle is cycle value plus one.
// - trigger mode cycle match and clear on the step after equal to buffer.
// - trigger mode second match when counter equals the second buffer.
// - trigger is a valid input edge or software writing one to trigger bit.
// - software triggers make timer output a a square wave of half period one cycle.
// - edge select register picks the valid trigger edge.
// - counter readback returns the live count without disturbing it.
// - trigger mode ignores capture input control and option settings.
// - trigger mode reloads both buffers at counter clear after a second value write.
module event_trigger_timer #(
	parameter logic [7:0] COUNT_DIV = 8'h01
) (
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire pwm_timer_pkg::addr_t addr,
	input  wire pwm_timer_pkg::word_t wdata,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output pwm_timer_pkg::word_t      rdata,
	input  wire logic                 ext_trigger_in,
	output logic                      timer_out_a,
	output logic                      pwm_out,
	output logic                      cycle_match_irq,
	output logic                      second_match_irq
);
	import pwm_timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic edge_hit(input edge_sel_t sel, input logic cur, input logic prev);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = ~cur & prev;
		case (sel)
			EDGE_RISING:  edge_hit = rise;
			EDGE_FALLING: edge_hit = fall;
			EDGE_BOTH:    edge_hit = rise | fall;
			default:      edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic         count_enable_bit_q;
	logic [2:0]   mode_q;
	logic [3:0]   trigger_edge_select_q;
	logic [3:0]   capture_input_ctrl_q;
	logic [3:0]   option_q;
	word_t        cycle_compare_reg_q;
	word_t        second_compare_reg_q;
	word_t        cycle_compare_buffer_q;
	word_t        second_compare_buffer_q;
	word_t        count_q;
	word_t        count_d;
	word_t        cyc_buf_d;
	word_t        sec_buf_d;
	timer_state_t state_q;
	timer_state_t state_d;
	logic         wrap_flag_q;
	logic         wrap_set;
	logic         reload_pending_q;
	logic         reload_now;
	logic         out_a_d;
	logic         pwm_d;
	logic         cyc_irq_d;
	logic         sec_irq_d;
	logic         sync1_q;
	logic         sync2_q;
	logic         prev_q;
	logic [7:0]   div_q;
	word_t        rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// register decode

	wire sel_ctrl0  = (addr == `ADR_CTRL0);
	wire sel_ctrl1  = (addr == `ADR_CTRL1);
	wire sel_edge   = (addr == `ADR_EDGE);
	wire sel_cycle  = (addr == `ADR_CYCLE);
	wire sel_second = (addr == `ADR_SECOND);
	wire sel_count  = (addr == `ADR_COUNT);
	wire sel_option = (addr == `ADR_OPTION);
	wire sel_capctl = (addr == `ADR_CAPCTL);

	wire wr_ctrl0   = wr_en & sel_ctrl0;
	wire wr_cycle   = wr_en & sel_cycle;
	wire wr_second  = wr_en & sel_second;
	wire wr_option  = wr_en & sel_option;

	wire ce_write    = wdata[`CE_BIT];
	wire ce_rise     = wr_ctrl0 & ce_write & ~count_enable_bit_q;
	wire ce_fall     = wr_ctrl0 & ~ce_write;
	wire sw_trigger  = wr_en & sel_ctrl1 & wdata[`SWTRIG_BIT];
	wire wrap_clear  = wr_option & ~wdata[`WRAP_BIT];

	wire is_event    = (mode_q == `MODE_EVENT);
	wire is_trigger  = (mode_q == `MODE_TRIGGER);

	word_t read_mux;
	assign read_mux =
		sel_ctrl0  ? {15'h0000, count_enable_bit_q} :
		sel_ctrl1  ? {13'h0000, mode_q} :
		sel_edge   ? {12'h000, trigger_edge_select_q} :
		sel_cycle  ? cycle_compare_reg_q :
		sel_second ? second_compare_reg_q :
		sel_count  ? count_q :
		sel_option ? {8'h00, option_q, 3'b000, wrap_flag_q} :
		sel_capctl ? {12'h000, capture_input_ctrl_q} :
		`DATA_ZERO;

	////////////////////////////////////////////////////////////////////////////////
	// input edge detection and count clock enable

	wire edge_sel_t trig_sel = edge_sel_t'(
		trigger_edge_select_q[`TRIG_SEL_MSB:`TRIG_SEL_LSB]);
	wire edge_sel_t evt_sel  = edge_sel_t'(
		trigger_edge_select_q[`EVT_SEL_MSB:`EVT_SEL_LSB]);
	wire trig_edge  = edge_hit(trig_sel, sync2_q, prev_q);
	wire event_edge = edge_hit(evt_sel, sync2_q, prev_q);
	wire count_tick = (div_q == (COUNT_DIV - `DIV_ONE));
	wire trigger    = is_trigger & (trig_edge | sw_trigger);

	// trigger mode steps on the count clock, event mode on edges
	wire step       = is_event ? event_edge : (is_trigger & count_tick);
	wire at_cycle   = (count_q == cycle_compare_buffer_q);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_d    = state_q;
		count_d    = count_q;
		cyc_buf_d  = cycle_compare_buffer_q;
		sec_buf_d  = second_compare_buffer_q;
		out_a_d    = timer_out_a;
		pwm_d      = pwm_out;
		cyc_irq_d  = 1'b0;
		sec_irq_d  = 1'b0;
		wrap_set   = 1'b0;
		reload_now = 1'b0;
		case (state_q)
			ST_IDLE: begin
				count_d = `CNT_ALL_ONES;
				out_a_d = 1'b0;
				pwm_d   = 1'b0;
				if (ce_rise) begin
					state_d   = ST_WAIT;
					cyc_buf_d = cycle_compare_reg_q;
					sec_buf_d = second_compare_reg_q;
				end
			end
			ST_WAIT: begin
				if (is_event && event_edge) begin
					state_d = ST_RUN;
					count_d = `CNT_ZERO;
					sec_irq_d = (second_compare_buffer_q == `CNT_ZERO);
				end else if (trigger) begin
					state_d    = ST_RUN;
					count_d    = `CNT_ZERO;
					pwm_d      = 1'b1;
					reload_now = reload_pending_q;
				end
			end
			ST_RUN: begin
				if (trigger) begin
					count_d    = `CNT_ZERO;
					out_a_d    = ~timer_out_a;
					pwm_d      = 1'b1;
					reload_now = reload_pending_q;
				end else if (step) begin
					if (at_cycle) begin
						count_d   = `CNT_ZERO;
						cyc_irq_d = 1'b1;
						if (is_trigger) begin
							out_a_d    = ~timer_out_a;
							pwm_d      = 1'b1;
							reload_now = reload_pending_q;
						end
					end else begin
						count_d  = count_q + `CNT_ONE;
						wrap_set = is_event && (count_q == `CNT_ALL_ONES);
					end
					// second match on the value the counter steps to
					if ((count_d == (reload_now ? second_compare_reg_q
						: second_compare_buffer_q))) begin
						sec_irq_d = 1'b1;
						if (is_trigger) begin
							pwm_d = 1'b0;
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// timer output a and pwm output stay quiet in every mode but trigger mode
		if (!is_trigger) begin
			out_a_d = 1'b0;
			pwm_d   = 1'b0;
		end
		if (reload_now) begin
			cyc_buf_d = cycle_compare_reg_q;
			sec_buf_d = second_compare_reg_q;
		end
		if (is_event && wr_cycle && state_q != ST_IDLE) begin
			cyc_buf_d = wdata;
		end
		if (is_event && wr_second && state_q != ST_IDLE) begin
			sec_buf_d = wdata;
		end
		if (ce_fall) begin
			state_d   = ST_IDLE;
			count_d   = `CNT_ALL_ONES;
			cyc_irq_d = 1'b0;
			sec_irq_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers written by software

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_enable_bit_q    <= 1'b0;
			mode_q                <= `MODE_RESET;
			trigger_edge_select_q <= `FIELD_RESET;
			capture_input_ctrl_q  <= `FIELD_RESET;
			option_q              <= `FIELD_RESET;
			cycle_compare_reg_q   <= `CMP_RESET;
			second_compare_reg_q  <= `CMP_RESET;
		end else if (wr_en) begin
			if (sel_ctrl0) begin
				count_enable_bit_q <= ce_write;
			end
			if (sel_ctrl1) begin
				mode_q <= wdata[`MODE_MSB:`MODE_LSB];
			end
			if (sel_edge) begin
				trigger_edge_select_q <= wdata[`EVT_SEL_MSB:`TRIG_SEL_LSB];
			end
			if (sel_capctl) begin
				capture_input_ctrl_q <= wdata[`CAP_MSB:`CAP_LSB];
			end
			if (sel_option) begin
				option_q <= wdata[`OPT_MSB:`OPT_LSB];
			end
			if (sel_cycle) begin
				cycle_compare_reg_q <= wdata;
			end
			if (sel_second) begin
				second_compare_reg_q <= wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// counter, buffers, outputs

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q                 <= ST_IDLE;
			count_q                 <= `CNT_ALL_ONES;
			cycle_compare_buffer_q  <= `CMP_RESET;
			second_compare_buffer_q <= `CMP_RESET;
			timer_out_a             <= 1'b0;
			pwm_out                 <= 1'b0;
			cycle_match_irq         <= 1'b0;
			second_match_irq        <= 1'b0;
		end else begin
			state_q                 <= state_d;
			count_q                 <= count_d;
			cycle_compare_buffer_q  <= cyc_buf_d;
			second_compare_buffer_q <= sec_buf_d;
			timer_out_a             <= out_a_d;
			pwm_out                 <= pwm_d;
			cycle_match_irq         <= cyc_irq_d;
			second_match_irq        <= sec_irq_d;
		end
	end

	// set wins over clear for both flags
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wrap_flag_q      <= 1'b0;
			reload_pending_q <= 1'b0;
		end else begin
			wrap_flag_q      <= wrap_set | (wrap_flag_q & ~wrap_clear);
			reload_pending_q <= (is_trigger & wr_second) | (reload_pending_q & ~reload_now);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// synchroniser, divider, read port

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= ext_trigger_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= `DIV_ZERO;
		end else if (count_tick || trigger || state_q != ST_RUN) begin
			div_q <= `DIV_ZERO;
		end else begin
			div_q <= div_q + `DIV_ONE;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= `DATA_ZERO;
		end else if (rd_en) begin
			rdata_q <= read_mux;
		end else begin
			rdata_q <= `DATA_ZERO;
		end
	end

	assign rdata = rdata_q;

endmodule : event_trigger_timer

// ===== verification/trig_source.sv
`timescale 1ns/1ps
module trig_source (
	input  wire logic core_clk,
	input  wire logic pwm_out,
	output logic      ext_trigger_in
);
	// pin rests low with no source attached; pwm_out is only a load
	initial ext_trigger_in = 1'b0;
	////////////////////////////////////////////////////////////////
	task automatic toggle(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge core_clk);
			ext_trigger_in <= ~ext_trigger_in;
		end
	endtask : toggle
endmodule : trig_source

// ===== verification/event_trigger_timer_checker.sv
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"
module event_trigger_timer_checker #(
	parameter logic [7:0] COUNT_DIV = 8'h01
) (
	input wire logic                 core_clk,
	input wire logic                 arst_n,
	input wire pwm_timer_pkg::addr_t addr,
	input wire pwm_timer_pkg::word_t wdata,
	input wire logic                 wr_en,
	input wire logic                 rd_en,
	input wire pwm_timer_pkg::word_t rdata,
	input wire logic                 ext_trigger_in,
	input wire logic                 timer_out_a,
	input wire logic                 pwm_out,
	input wire logic                 cycle_match_irq,
	input wire logic                 second_match_irq
);
	import pwm_timer_pkg::*;
	logic [2:0] mode_q;
	logic       ce_q;
	logic       pin_q;
	logic [3:0] chg_q;
	wire        trig_mode = mode_q == `MODE_TRIGGER;
	wire        chg_step  = chg_q != 4'hf;
	// shadow of mode and enable; cycles since the pin last moved
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= 3'h0;
			ce_q   <= 1'b0;
			pin_q  <= 1'b0;
			chg_q  <= 4'hf;
		end else begin
			if (wr_en && addr == `ADR_CTRL1)
				mode_q <= wdata[2:0];
			if (wr_en && addr == `ADR_CTRL0)
				ce_q <= wdata[`CE_BIT];
			pin_q <= ext_trigger_in;
			chg_q <= (ext_trigger_in != pin_q) ? 4'h0 : chg_q + {3'h0, chg_step};
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	read_idle_a: assert property (!$past(rd_en) |-> rdata == `DATA_ZERO)
		else $error("read data not zero outside a read");
	idle_count_a: assert property (!ce_q && rd_en && addr == `ADR_COUNT
		|=> rdata == `CNT_ALL_ONES) else $error("stopped counter not all ones");
	sw_trig_a: assert property (trig_mode && ce_q && wr_en && addr == `ADR_CTRL1
		&& wdata[`SWTRIG_BIT] && wdata[2:0] == `MODE_TRIGGER |=> pwm_out)
		else $error("software trigger left pwm low");
	cycle_toggle_a: assert property (trig_mode && cycle_match_irq
		|-> timer_out_a != $past(timer_out_a)) else $error("no toggle on cycle match");
	second_low_a: assert property (trig_mode && second_match_irq |-> !pwm_out)
		else $error("pwm high at second match");
	pwm_fall_a: assert property (trig_mode && ce_q && $fell(pwm_out)
		|-> second_match_irq) else $error("pwm fell without second match");
	quiet_mode_a: assert property ((!trig_mode) [*2] |-> !pwm_out && !timer_out_a)
		else $error("outputs active outside trigger mode");
	idle_irq_a: assert property ((!ce_q) [*2] |-> !cycle_match_irq && !second_match_irq)
		else $error("match pulse while stopped");
	event_lag_a: assert property (mode_q == `MODE_EVENT
		&& (cycle_match_irq || second_match_irq) |-> chg_q <= 4'h4)
		else $error("event match not caused by a pin edge");
	cover property (trig_mode && cycle_match_irq);
	cover property (mode_q == `MODE_EVENT && second_match_irq);
	cover property (trig_mode && $rose(timer_out_a));
endmodule : event_trigger_timer_checker

bind event_trigger_timer event_trigger_timer_checker #(.COUNT_DIV(COUNT_DIV)) u_chk (
	.core_clk, .arst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .ext_trigger_in,
	.timer_out_a, .pwm_out, .cycle_match_irq, .second_match_irq);

// ===== verification/tb_event_trigger_timer.sv
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"
module tb_event_trigger_timer;
	import pwm_timer_pkg::*;
	logic  core_clk, arst_n, wr_en, rd_en, ext_trigger_in, prev;
	logic  timer_out_a, pwm_out, cycle_match_irq, second_match_irq;
	addr_t addr;
	word_t wdata, rdata, d, hi, ncc, nsc, ntg;
	int    failures = 0;
	int    cmp_count = 0;
	// cycle, second, pwm high cycles, cycle matches, second matches over two periods
	word_t rows [4][5] = '{'{16'h3, 16'h1, 16'h2, 16'h1, 16'h2},
		'{16'h5, 16'h2, 16'h4, 16'h1, 16'h2}, '{16'h4, 16'h5, 16'ha, 16'h1, 16'h0},
		'{16'h6, 16'h6, 16'hc, 16'h1, 16'h2}};
	event_trigger_timer #(.COUNT_DIV(`DIV_ONE)) u_dut (.core_clk, .arst_n, .addr, .wdata,
		.wr_en, .rd_en, .rdata, .ext_trigger_in, .timer_out_a, .pwm_out, .cycle_match_irq,
		.second_match_irq);
	trig_source u_src (.core_clk, .pwm_out, .ext_trigger_in);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		hi += pwm_out;
		ncc += cycle_match_irq;
		nsc += second_match_irq;
		ntg += timer_out_a ^ prev;
		prev = timer_out_a;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input word_t got, input word_t exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input addr_t a, input word_t v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input addr_t a);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic clr();
		{hi, ncc, nsc, ntg} = '0;
	endtask : clr
	task automatic setup(input word_t c, input word_t s, input word_t m, input word_t e);
		wr(`ADR_CTRL0, 16'h0000);
		wr(`ADR_CYCLE, c);
		wr(`ADR_SECOND, s);
		wr(`ADR_CTRL1, m);
		wr(`ADR_EDGE, e);
		wr(`ADR_CTRL0, 16'h0001);
	endtask : setup
	task automatic run(input int p);
		wr(`ADR_CTRL1, 16'h000a);
		clr();
		repeat (2 * p) @(posedge core_clk);
	endtask : run
	task automatic exp4(input word_t a, input word_t b, input word_t c, input word_t e);
		chk(hi, a);
		chk(ncc, b);
		chk(nsc, c);
		chk(ntg, e);
	endtask : exp4
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (100000) @(posedge core_clk);
		failures++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{arst_n, wr_en, rd_en, addr, wdata} = '0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(`ADR_CYCLE);
		chk(d, `CMP_RESET);
		wr(`ADR_EDGE, 16'hffff);
		rd(`ADR_EDGE);
		chk(d, `EDGE_W_MASK);
		wr(`ADR_COUNT, 16'h1234);
		rd(`ADR_COUNT);
		chk(d, `CNT_ALL_ONES);
		rd(8'h20);
		chk(d, `DATA_ZERO);
		wr(`ADR_OPTION, 16'h00f0);
		wr(`ADR_CAPCTL, 16'h000f);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			setup(rows[i][0], rows[i][1], 16'h0002, 16'h0000);
			rd(`ADR_COUNT);
			chk(d, `CNT_ALL_ONES);
			run(int'(rows[i][0]) + 1);
			exp4(rows[i][2], rows[i][3], rows[i][4], 16'h1);
		end
		$display("pwm table done");
		setup(16'h3, 16'h1, 16'h2, 16'h0);
		run(4);
		wr(`ADR_CYCLE, 16'h0005);
		run(4);
		exp4(16'h2, 16'h1, 16'h2, 16'h2);
		wr(`ADR_SECOND, 16'h0002);
		run(6);
		exp4(16'h4, 16'h1, 16'h2, 16'h2);
		$display("retrigger and reload done");
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 2; j++) begin
				wr(`ADR_CTRL0, 16'h0000);
				wr(`ADR_EDGE, word_t'(i));
				if (ext_trigger_in != j[0])
					u_src.toggle(1, 1);
				repeat (6) @(posedge core_clk);
				wr(`ADR_CTRL0, 16'h0001);
				u_src.toggle(1, 3);
				repeat (8) @(posedge core_clk);
				rd(`ADR_COUNT);
				chk(d != `CNT_ALL_ONES, i[j]);
			end
		end
		$display("trigger edge test done");
		setup(16'h0014, 16'h0007, 16'h0001, 16'h000c);
		clr();
		u_src.toggle(11, 2);
		repeat (8) @(posedge core_clk);
		rd(`ADR_COUNT);
		chk(d, 16'h000a);
		chk(nsc, 16'h1);
		// cycle value lowered while counting, on purpose
		wr(`ADR_CYCLE, 16'h0005);
		clr();
		u_src.toggle(65525, 1);
		repeat (8) @(posedge core_clk);
		rd(`ADR_COUNT);
		chk(d, `CNT_ALL_ONES);
		chk(ncc + nsc, 16'h0);
		wr(`ADR_CYCLE, `CNT_ALL_ONES);
		u_src.toggle(1, 1);
		repeat (8) @(posedge core_clk);
		chk(ncc, 16'h1);
		rd(`ADR_OPTION);
		chk(d, 16'h00f0);
		wr(`ADR_CYCLE, 16'h0005);
		wr(`ADR_SECOND, 16'h0003);
		clr();
		u_src.toggle(12, 1);
		repeat (8) @(posedge core_clk);
		exp4(16'h0, 16'h2, 16'h2, 16'h0);
		$display("event count test done");
		// reset in mid-run, counter busy in event mode
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		chk({pwm_out, timer_out_a, cycle_match_irq, second_match_irq}, 16'h0);
		rd(`ADR_SECOND);
		chk(d, `CMP_RESET);
		rd(`ADR_COUNT);
		chk(d, `CNT_ALL_ONES);
		$display("reset test done");
		end_of_test();
	end
endmodule : tb_event_trigger_timer
